/* File: cnd_dispatch.sv */
`timescale 1ns/1ps
// Operation
// - 11-bit id: 7-bit node, 4-bit function
// - own node address 1..127, bits 0-6
// - id 0 is nmt, id 128 is sync
// - emergency sent on 128 plus node
// - first tpdo sent on function 0011
// - first rpdo taken on function 0100
// - second tpdo sent on function 0101
// - second rpdo taken on function 0110
// - third tpdo sent on function 0111
// - third rpdo taken on function 1000
// - fourth tpdo sent on function 1001
// - fourth rpdo taken on function 1010
// - sdo responses sent on function 1011
// - sdo requests taken on function 1100
// - transmit goes out, receive comes in
// - nmt specifier 1 enters operational
// - nmt specifier 2 enters stopped
// - nmt node 0 addresses every slave
// - extended identifiers are dropped
// - new pdo ids apply on entering operational
module cnd_dispatch (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [6:0] node_addr,
  input wire logic rx_valid,
  input wire cnd_pkg::cnd_frame_s rx_frame,
  input wire logic tx_req,
  input wire cnd_pkg::cnd_tx_e tx_kind,
  input wire logic cfg_we,
  input wire logic [2:0] cfg_sel,
  input wire logic [10:0] cfg_id,
  output cnd_pkg::cnd_route_s route,
  output cnd_pkg::cnd_state_e state,
  output logic tx_valid,
  output logic [10:0] tx_id,
  output logic node_reset,
  output logic comm_reset,
  output logic ext_drop
);

  // ***********************
  // helpers
  // ***********************
  // slot 0..3 transmit pdo, slot 4..7 receive pdo
  function automatic logic [10:0] dflt_id(
    input logic [2:0] slot,
    input logic [6:0] node
  );
    logic [3:0] fc;
    fc = slot[2] ? cnd_pkg::FC_RPDO1 : cnd_pkg::FC_TPDO1;
    fc = fc + 4'(slot[1:0]) * cnd_pkg::FC_PDO_STEP;
    dflt_id = {fc, node};
  endfunction

  cnd_pkg::cnd_state_e state_q, state_d;
  cnd_pkg::cnd_route_s route_q, route_d;
  logic [7:0][10:0] pend_q, act_q;
  logic tx_valid_q, tx_ok;
  logic [10:0] tx_id_q, tx_id_d;
  logic node_reset_q, comm_reset_q, ext_drop_q;

  // ***********************
  // decode
  // ***********************
  wire logic [3:0] rx_fc = rx_frame.id[10:7];
  wire logic [6:0] rx_nid = rx_frame.id[6:0];
  wire logic std_ok = rx_valid && !rx_frame.ide;
  wire logic node_ok = node_addr != cnd_pkg::NODE_BCAST;
  wire logic in_oper = state_q == cnd_pkg::CND_OPER;
  wire logic in_pre = state_q == cnd_pkg::CND_PREOP;
  wire logic talk = in_oper || in_pre;
  wire logic is_nmt = std_ok && rx_frame.id == cnd_pkg::ID_NMT;
  wire logic nmt_me = rx_frame.node == {1'b0, node_addr};
  wire logic nmt_all = rx_frame.node == cnd_pkg::NODE_BCAST_B;
  // a non-zero foreign node address never reaches the state logic
  wire logic nmt_hit = is_nmt && (nmt_all || (node_ok && nmt_me));
  wire logic sync_hit = std_ok && talk &&
    rx_frame.id == cnd_pkg::ID_SYNC;
  wire logic sdo_hit = std_ok && talk && node_ok &&
    rx_fc == cnd_pkg::FC_SDO_RX && rx_nid == node_addr;

  // receive pdos only while operational, on the active ids
  logic [3:0] rpdo_hit;
  genvar gi;
  generate
    for (gi = 0; gi < cnd_pkg::NUM_PDO; gi++) begin : g_rpdo
      assign rpdo_hit[gi] = std_ok && in_oper && node_ok &&
        rx_frame.id == act_q[gi + 4];
    end
  endgenerate

  always_comb begin
    route_d.nmt = nmt_hit;
    route_d.sync = sync_hit;
    route_d.rpdo = rpdo_hit;
    route_d.sdo = sdo_hit;
  end

  // ***********************
  // node state
  // ***********************
  wire logic go_boot = nmt_hit &&
    (rx_frame.cs == cnd_pkg::CS_RST_NODE ||
     rx_frame.cs == cnd_pkg::CS_RST_COMM);

  always_comb begin
    state_d = state_q;
    if (state_q == cnd_pkg::CND_BOOT) begin
      state_d = cnd_pkg::CND_PREOP;
    end else if (nmt_hit) begin
      unique case (rx_frame.cs)
        cnd_pkg::CS_START: state_d = cnd_pkg::CND_OPER;
        cnd_pkg::CS_STOP: state_d = cnd_pkg::CND_STOP;
        cnd_pkg::CS_PREOP: state_d = cnd_pkg::CND_PREOP;
        cnd_pkg::CS_RST_NODE: state_d = cnd_pkg::CND_BOOT;
        cnd_pkg::CS_RST_COMM: state_d = cnd_pkg::CND_BOOT;
        default: state_d = state_q;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= cnd_pkg::CND_BOOT;
      route_q <= '0;
      node_reset_q <= 1'b0;
      comm_reset_q <= 1'b0;
      ext_drop_q <= 1'b0;
    end else begin
      state_q <= state_d;
      route_q <= route_d;
      node_reset_q <= nmt_hit &&
        rx_frame.cs == cnd_pkg::CS_RST_NODE;
      comm_reset_q <= nmt_hit &&
        rx_frame.cs == cnd_pkg::CS_RST_COMM;
      ext_drop_q <= rx_valid && rx_frame.ide;
    end
  end

  // ***********************
  // pdo identifiers
  // ***********************
  // defaults follow the node address, so they are loaded in boot,
  // never by the asynchronous reset itself
  wire logic enter_oper = state_d == cnd_pkg::CND_OPER && !in_oper;
  wire logic cfg_take = cfg_we && !in_oper;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pend_q <= '0;
      act_q <= '0;
    end else if (state_q == cnd_pkg::CND_BOOT) begin
      for (int i = 0; i < 8; i++) begin
        pend_q[i] <= dflt_id(3'(i), node_addr);
        act_q[i] <= dflt_id(3'(i), node_addr);
      end
    end else begin
      if (cfg_take) begin
        pend_q[cfg_sel] <= cfg_id;
      end
      if (enter_oper) begin
        act_q <= pend_q;
      end
    end
  end

  // ***********************
  // transmit identifiers
  // ***********************
  always_comb begin
    tx_ok = 1'b0;
    tx_id_d = '0;
    unique case (tx_kind)
      cnd_pkg::CND_TX_EMCY: begin
        tx_ok = talk;
        tx_id_d = {cnd_pkg::FC_EMCY, node_addr};
      end
      cnd_pkg::CND_TX_PDO1, cnd_pkg::CND_TX_PDO2,
      cnd_pkg::CND_TX_PDO3, cnd_pkg::CND_TX_PDO4: begin
        tx_ok = in_oper;
        tx_id_d = act_q[3'(tx_kind - 3'h1)];
      end
      cnd_pkg::CND_TX_SDO: begin
        tx_ok = talk;
        tx_id_d = {cnd_pkg::FC_SDO_TX, node_addr};
      end
      default: begin
        tx_ok = 1'b0;
        tx_id_d = '0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_valid_q <= 1'b0;
      tx_id_q <= '0;
    end else begin
      tx_valid_q <= tx_req && tx_ok && node_ok;
      if (tx_req && tx_ok && node_ok) begin
        tx_id_q <= tx_id_d;
      end
    end
  end

  assign route = route_q;
  assign state = state_q;
  assign tx_valid = tx_valid_q;
  assign tx_id = tx_id_q;
  assign node_reset = node_reset_q;
  assign comm_reset = comm_reset_q;
  assign ext_drop = ext_drop_q;

  // ***********************
  // checks
  // ***********************
  a_ext_dropped: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    rx_valid && rx_frame.ide |=> route_q == '0 && ext_drop_q)
    else $error("extended frame was routed");

  a_start_oper: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    nmt_hit && !(state_q == cnd_pkg::CND_BOOT) &&
    rx_frame.cs == cnd_pkg::CS_START
    |=> state_q == cnd_pkg::CND_OPER && route_q.nmt)
    else $error("start did not reach operational");

  a_stop_state: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    nmt_hit && state_q != cnd_pkg::CND_BOOT &&
    rx_frame.cs == cnd_pkg::CS_STOP
    |=> state_q == cnd_pkg::CND_STOP)
    else $error("stop did not reach stopped");

  a_bcast_nmt: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    std_ok && rx_frame.id == 11'h000 && rx_frame.node == 8'h00 &&
    state_q != cnd_pkg::CND_BOOT
    |=> route_q.nmt)
    else $error("broadcast nmt not taken");

  a_foreign_skip: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    rx_valid && rx_frame.node != 8'h00 &&
    rx_frame.node != {1'b0, node_addr} &&
    state_q != cnd_pkg::CND_BOOT
    |=> $stable(state_q) && !route_q.nmt)
    else $error("foreign nmt acted on");

  a_reset_node: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    nmt_hit && rx_frame.cs == cnd_pkg::CS_RST_NODE
    |=> node_reset_q && !comm_reset_q ##1
    state_q == cnd_pkg::CND_PREOP && !node_reset_q)
    else $error("node reset sequence wrong");

  a_sync_route: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    route_q.sync |-> $past(rx_frame.id) == 11'h080 &&
    $past(state_q) inside {cnd_pkg::CND_OPER, cnd_pkg::CND_PREOP})
    else $error("sync routed on wrong id");

  a_emcy_id: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    tx_valid_q && $past(tx_kind) == cnd_pkg::CND_TX_EMCY
    |-> tx_id_q >= 11'd129 && tx_id_q <= 11'd255 &&
    tx_id_q[6:0] == $past(node_addr))
    else $error("emergency id out of range");

  a_sdo_ids: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    tx_valid_q && $past(tx_kind) == cnd_pkg::CND_TX_SDO
    |-> tx_id_q >= 11'd1409 && tx_id_q <= 11'd1535)
    else $error("sdo response id out of range");

  a_sdo_rx: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    route_q.sdo |-> $past(rx_frame.id) >= 11'd1537 &&
    $past(rx_frame.id) <= 11'd1663)
    else $error("sdo request id out of range");

  a_pdo_held: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    in_oper && state_d == cnd_pkg::CND_OPER |=> $stable(act_q))
    else $error("pdo id changed while operational");

  a_reset_boot: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    go_boot && state_q != cnd_pkg::CND_BOOT
    |=> state_q == cnd_pkg::CND_BOOT)
    else $error("reset command did not reach boot");

  a_rpdo_oper: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    route_q.rpdo != 4'h0 |-> $past(state_q) == cnd_pkg::CND_OPER &&
    $past(std_ok))
    else $error("receive pdo routed outside operational");

  a_tx_mute: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    tx_valid_q |-> $past(node_addr) != cnd_pkg::NODE_BCAST)
    else $error("transmit granted without node address");

endmodule

/* File: cnd_master.sv */
`timescale 1ns/1ps
// ***********************
// network master model
// ***********************
module cnd_master (
  input wire logic ref_clk,
  output logic rx_valid,
  output cnd_pkg::cnd_frame_s rx_frame
);
  initial begin
    rx_valid = 1'b0;
    rx_frame = '0;
  end
  // receive objects come from the master only
  task automatic send(input logic ide, input logic [10:0] id,
                      input logic [7:0] cs, input logic [7:0] nd);
    // idle edge first: back-to-back frames never drive rx_valid twice
    // in one time step
    @(posedge ref_clk);
    #1;
    rx_frame = {ide, 1'b0, id, cs, nd};
    rx_valid = 1'b1;
    @(posedge ref_clk);
    #1;
    rx_valid = 1'b0;
    // released bus must not keep showing the last frame
    rx_frame = ~rx_frame;
  endtask
endmodule

/* File: cnd_pkg.sv */
package cnd_pkg;

  // ***********************
  // identifier layout
  // ***********************
  localparam int ID_W = 11;
  localparam int NODE_W = 7;
  localparam int FC_W = 4;
  localparam int FC_LSB = 7;
  localparam int NUM_PDO = 4;

  // ***********************
  // function codes
  // ***********************
  localparam logic [3:0] FC_NMT = 4'h0;
  localparam logic [3:0] FC_SYNC = 4'h1;
  localparam logic [3:0] FC_EMCY = 4'h1;
  localparam logic [3:0] FC_TPDO1 = 4'h3;
  localparam logic [3:0] FC_RPDO1 = 4'h4;
  localparam logic [3:0] FC_PDO_STEP = 4'h2;
  localparam logic [3:0] FC_SDO_TX = 4'hb;
  localparam logic [3:0] FC_SDO_RX = 4'hc;

  // ***********************
  // fixed identifiers
  // ***********************
  localparam logic [10:0] ID_NMT = 11'h000;
  localparam logic [10:0] ID_SYNC = 11'h080;
  localparam logic [6:0] NODE_BCAST = 7'h00;
  localparam logic [7:0] NODE_BCAST_B = 8'h00;

  // ***********************
  // command specifiers
  // ***********************
  localparam logic [7:0] CS_START = 8'h01;
  localparam logic [7:0] CS_STOP = 8'h02;
  localparam logic [7:0] CS_PREOP = 8'h80;
  localparam logic [7:0] CS_RST_NODE = 8'h81;
  localparam logic [7:0] CS_RST_COMM = 8'h82;

  typedef enum logic [1:0] {
    CND_BOOT = 2'b00,
    CND_STOP = 2'b01,
    CND_OPER = 2'b10,
    CND_PREOP = 2'b11
  } cnd_state_e;

  typedef enum logic [2:0] {
    CND_TX_EMCY = 3'h0,
    CND_TX_PDO1 = 3'h1,
    CND_TX_PDO2 = 3'h2,
    CND_TX_PDO3 = 3'h3,
    CND_TX_PDO4 = 3'h4,
    CND_TX_SDO = 3'h5
  } cnd_tx_e;

  typedef struct packed {
    logic ide;
    logic rtr;
    logic [10:0] id;
    logic [7:0] cs;
    logic [7:0] node;
  } cnd_frame_s;

  typedef struct packed {
    logic nmt;
    logic sync;
    logic [3:0] rpdo;
    logic sdo;
  } cnd_route_s;

endpackage

/* File: test_canopen_cobid_nmt_dispatch.sv */
`timescale 1ns/1ps
module test_canopen_cobid_nmt_dispatch;
  // ***********************
  // bench
  // ***********************
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [6:0] node_addr = 7'h01;
  logic [6:0] fn;
  logic rx_valid;
  cnd_pkg::cnd_frame_s rx_frame;
  logic tx_req = 1'b0;
  cnd_pkg::cnd_tx_e tx_kind = cnd_pkg::CND_TX_EMCY;
  logic cfg_we = 1'b0;
  logic [2:0] cfg_sel = 3'h0;
  logic [10:0] cfg_id = 11'h000;
  cnd_pkg::cnd_route_s route;
  cnd_pkg::cnd_state_e state;
  logic tx_valid;
  logic [10:0] tx_id;
  logic node_reset;
  logic comm_reset;
  logic ext_drop;
  int n_mismatch = 0;
  int compares = 0;
  int seed = 56421;
  int k;
  logic [7:0] rnd;

  cnd_master i_master (.ref_clk(ref_clk), .rx_valid(rx_valid),
    .rx_frame(rx_frame));
  cnd_dispatch i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .node_addr(node_addr), .rx_valid(rx_valid), .rx_frame(rx_frame),
    .tx_req(tx_req), .tx_kind(tx_kind), .cfg_we(cfg_we),
    .cfg_sel(cfg_sel), .cfg_id(cfg_id), .route(route), .state(state),
    .tx_valid(tx_valid), .tx_id(tx_id), .node_reset(node_reset),
    .comm_reset(comm_reset), .ext_drop(ext_drop));

  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask

  task automatic wrap_up();
    if (n_mismatch == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk_val(input logic [10:0] got, input logic [10:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_route(input logic [6:0] exp);
    compares++;
    if (route !== exp) begin
      n_mismatch++;
      $display("ERROR %0t route %h expected %h", $time, route, exp);
    end
  endtask

  task automatic chk_state(input cnd_pkg::cnd_state_e exp);
    chk_val({9'h000, state}, {9'h000, exp});
  endtask

  // identifier as function code over node address
  function automatic logic [10:0] mk_id(input logic [3:0] fc,
                                        input logic [6:0] nd);
    mk_id = {fc, nd};
  endfunction

  task automatic rx(input logic ide, input logic [10:0] id,
                    input logic [7:0] cs, input logic [7:0] nd);
    i_master.send(ide, id, cs, nd);
  endtask

  task automatic tx(input cnd_pkg::cnd_tx_e kd, input logic [10:0] exp);
    // idle edge first: tx_req is never lowered and raised in one step
    tick();
    tx_kind = kd;
    tx_req = 1'b1;
    tick();
    tx_req = 1'b0;
    chk_val({10'h000, tx_valid}, 11'h001);
    chk_val(tx_id, exp);
  endtask

  initial begin
    #100000;
    n_mismatch++;
    wrap_up();
  end

  initial begin
    // random own address, foreign one always non-zero and different
    node_addr = 7'(1 + ({$random(seed)} % 127));
    fn = 7'(node_addr % 7'd127 + 7'd1);
    repeat (5) tick();
    sys_rst = 1'b0;
    tick();
    tick();
    chk_state(cnd_pkg::CND_PREOP);
    rx(1'b0, cnd_pkg::ID_SYNC, 8'h00, 8'h00);
    chk_route(7'h20);
    rx(1'b0, {4'hc, node_addr}, 8'h00, 8'h00);
    chk_route(7'h01);
    tx(cnd_pkg::CND_TX_EMCY, mk_id(4'h1, node_addr));
    tx(cnd_pkg::CND_TX_SDO, mk_id(4'hb, node_addr));
    cfg_sel = 3'h5;
    cfg_id = {4'hd, node_addr};
    cfg_we = 1'b1;
    tick();
    cfg_we = 1'b0;
    rx(1'b0, cnd_pkg::ID_NMT, cnd_pkg::CS_START, 8'h00);
    chk_route(7'h40);
    chk_state(cnd_pkg::CND_OPER);
    rx(1'b0, {4'hd, node_addr}, 8'h00, 8'h00);
    chk_route(7'h04);
    rx(1'b0, {4'h6, node_addr}, 8'h00, 8'h00);
    chk_route(7'h00);
    for (k = 1; k <= 4; k++) begin
      if (k != 2) begin
        rx(1'b0, {4'(2 * k + 2), node_addr}, 8'h00, 8'h00);
        chk_route(7'(2 << (k - 1)));
      end
      tx(cnd_pkg::cnd_tx_e'(k),
         mk_id(4'(2 * k + 1), node_addr));
    end
    rx(1'b0, {4'h4, fn}, 8'h00, 8'h00);
    chk_route(7'h00);
    rx(1'b0, cnd_pkg::ID_NMT, cnd_pkg::CS_STOP, {1'b0, fn});
    chk_state(cnd_pkg::CND_OPER);
    // random foreign commands, any specifier, must all be ignored
    repeat (8) begin
      rnd = 8'($random(seed));
      if (rnd == 8'h00 || rnd == {1'b0, node_addr}) begin
        rnd = {1'b0, fn};
      end
      rx(1'b0, cnd_pkg::ID_NMT, 8'($random(seed)), rnd);
      chk_state(cnd_pkg::CND_OPER);
    end
    rx(1'b0, cnd_pkg::ID_NMT, cnd_pkg::CS_STOP, {1'b0, node_addr});
    chk_state(cnd_pkg::CND_STOP);
    rx(1'b1, {4'h4, node_addr}, 8'h00, 8'h00);
    chk_val({10'h000, ext_drop}, 11'h001);
    chk_route(7'h00);
    rx(1'b0, cnd_pkg::ID_NMT, cnd_pkg::CS_PREOP, {1'b0, node_addr});
    chk_state(cnd_pkg::CND_PREOP);
    for (k = 0; k < 2; k++) begin
      rx(1'b0, cnd_pkg::ID_NMT,
         k == 0 ? cnd_pkg::CS_RST_NODE : cnd_pkg::CS_RST_COMM, 8'h00);
      chk_val({9'h000, node_reset, comm_reset},
              k == 0 ? 11'h002 : 11'h001);
      chk_state(cnd_pkg::CND_BOOT);
      tick();
      chk_state(cnd_pkg::CND_PREOP);
    end
    wrap_up();
  end
endmodule
